// ===== src/dci_pkg.sv
/*
 * constants for the dma channel interrupt control block: register offsets,
 * field positions, reset values and the pointer width.
 * assumes a classic wishbone slave with 32-bit data and byte addressing.
 */
// Contract
// [RL1] eight interrupt enables in bits 23..16; one enables, zero disables
// [RL2] source done flag, bit 7, set when source pointer equals source size
// [RL3] source half empty flag, bit 6, set when source pointer equals half size
// [RL4] destination done flag, bit 5, set when destination pointer equals size
// [RL5] bits 31..24 and 15..8 of the control register always read zero
// [RL6] all enable and flag bits are read/write and clear to zero at reset
// [RL7] channel request high exactly while some flag and its enable are both set
package dci_pkg;
   localparam int          PTR_W          = 16;
   localparam int          ADR_W          = 8;
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_STATUS     = 8'h04;
   localparam logic [7:0]  OFS_MASK       = 8'h08;
   localparam int          ENA_LSB        = 16;
   localparam int          FLAG_LSB       = 0;
   localparam int          BIT_SRC_DONE   = 7;
   localparam int          BIT_SRC_HALF   = 6;
   localparam int          BIT_DST_DONE   = 5;
   localparam int          BIT_DST_HALF   = 4;
   localparam int          BIT_BLOCK      = 3;
   localparam int          BIT_CELL       = 2;
   localparam int          BIT_ABORT      = 1;
   localparam int          BIT_ADDR_ERR   = 0;
   localparam logic [7:0]  RST_ENABLES    = 8'h00;
   localparam logic [7:0]  RST_FLAGS      = 8'h00;
   localparam logic [7:0]  RST_MASK       = 8'h00;
   localparam logic [31:0] RST_DAT        = 32'h0000_0000;
endpackage : dci_pkg

// ===== src/dci_sticky.sv
/*
 * a row of sticky bits: hardware sets, software loads or clears.
 * assumes set, load and clear are synchronous single-cycle strobes.
 */
`timescale 1ns/10ps
module dci_sticky #(
   parameter int W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] set_i,
   input  wire logic [W-1:0] load_i,
   input  wire logic [W-1:0] load_val_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] bits_ff;

   // a set arriving with a load or clear wins, so no event is lost
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bits_ff <= '0;
      end else begin
         bits_ff <= set_i | (load_i & load_val_i) | (~load_i & bits_ff);
      end
   end

   assign q_o = bits_ff;
endmodule : dci_sticky

// ===== src/dci_hit.sv
/*
 * compares a running pointer with its size and gives one-cycle pulses
 * when it reaches the end and the midpoint.
 * assumes pointer and size are synchronous to clk_i.
 */
`timescale 1ns/10ps
module dci_hit #(
   parameter int W = 16
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] ptr_i,
   input  wire logic [W-1:0] size_i,
   output logic              done_o,
   output logic              half_o
);
   logic done_lvl;
   logic half_lvl;
   logic done_ff;
   logic half_ff;

   assign done_lvl = (ptr_i == size_i);
   assign half_lvl = (ptr_i == (size_i >> 1));

   // edge, not level: a pointer parked at the end must not re-set a cleared flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_ff <= 1'b1;
         half_ff <= 1'b1;
      end else begin
         done_ff <= done_lvl;
         half_ff <= half_lvl;
      end
   end

   assign done_o = done_lvl & ~done_ff;
   assign half_o = half_lvl & ~half_ff;
endmodule : dci_hit

// ===== src/dci_top.sv
/*
 * dma channel interrupt control: enables, event flags, channel request,
 * plus a read-to-clear event status and mask feeding a system interrupt.
 * assumes a classic wishbone master on clk_i and pointer counters on clk_i.
 */
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/10ps
module dci_top (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      cyc_i,
   input  wire logic                      stb_i,
   input  wire logic                      we_i,
   input  wire logic [dci_pkg::ADR_W-1:0] adr_i,
   input  wire logic [3:0]                sel_i,
   input  wire logic [31:0]               dat_i,
   output logic      [31:0]               dat_o,
   output logic                           ack_o,
   input  wire logic [dci_pkg::PTR_W-1:0] source_pointer_i,
   input  wire logic [dci_pkg::PTR_W-1:0] source_size_i,
   input  wire logic [dci_pkg::PTR_W-1:0] dest_pointer_i,
   input  wire logic [dci_pkg::PTR_W-1:0] dest_size_i,
   input  wire logic                      dest_half_full_i,
   input  wire logic                      block_complete_i,
   input  wire logic                      cell_complete_i,
   input  wire logic                      transfer_abort_i,
   input  wire logic                      address_error_i,
   output logic                           chan_irq_o,
   output logic                           irq_o
);
   logic        ack_ff;
   logic [31:0] dat_ff;
   logic [7:0]  enables_ff;
   logic [7:0]  mask_ff;
   logic [7:0]  flags;
   logic [7:0]  status;
   logic [7:0]  events;
   logic [7:0]  flag_load;
   logic [7:0]  stat_clr;
   logic [7:0]  stat_keep;
   logic [31:0] nxt_dat;
   logic        src_done;
   logic        src_half;
   logic        dst_done;
   logic        req;
   logic        wr_edge;
   logic        rd_edge;
   logic        hit_ctrl;
   logic        hit_status;
   logic        hit_mask;

   // bus slave: one wait state, ack for one cycle, every address answered
   assign req        = cyc_i & stb_i;
   assign hit_ctrl   = (adr_i == dci_pkg::OFS_CTRL);
   assign hit_status = (adr_i == dci_pkg::OFS_STATUS);
   assign hit_mask   = (adr_i == dci_pkg::OFS_MASK);
   assign wr_edge    = req & ack_ff & we_i;
   assign rd_edge    = req & ack_ff & ~we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   always_comb begin
      nxt_dat = 32'h0000_0000;  // RL5
      if (hit_ctrl) begin
         nxt_dat[dci_pkg::ENA_LSB +: 8]  = enables_ff;  // RL1
         nxt_dat[dci_pkg::FLAG_LSB +: 8] = flags;       // RL6
      end else if (hit_status) begin
         nxt_dat[7:0] = status;
      end else if (hit_mask) begin
         nxt_dat[7:0] = mask_ff;
      end
   end

   // read data is captured as ack rises and held while ack stands
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_ff <= dci_pkg::RST_DAT;
      end else if (req & ~ack_ff & ~we_i) begin
         dat_ff <= nxt_dat;
      end
   end

   assign ack_o = ack_ff;
   assign dat_o = dat_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enables_ff <= dci_pkg::RST_ENABLES;  // RL6
      end else if (wr_edge & hit_ctrl & sel_i[2]) begin
         enables_ff <= dat_i[dci_pkg::ENA_LSB +: 8];  // RL1 RL6
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_ff <= dci_pkg::RST_MASK;
      end else if (wr_edge & hit_mask & sel_i[0]) begin
         mask_ff <= dat_i[7:0];
      end
   end

   // event sources
   dci_hit #(.W(dci_pkg::PTR_W)) u_src_hit (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ptr_i  (source_pointer_i),
      .size_i (source_size_i),
      .done_o (src_done),
      .half_o (src_half)
   );

   dci_hit #(.W(dci_pkg::PTR_W)) u_dst_hit (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ptr_i  (dest_pointer_i),
      .size_i (dest_size_i),
      .done_o (dst_done),
      .half_o ()
   );

   always_comb begin
      events                         = 8'h00;
      events[dci_pkg::BIT_SRC_DONE]  = src_done;  // RL2
      events[dci_pkg::BIT_SRC_HALF]  = src_half;  // RL3
      events[dci_pkg::BIT_DST_DONE]  = dst_done;  // RL4
      events[dci_pkg::BIT_DST_HALF]  = dest_half_full_i;
      events[dci_pkg::BIT_BLOCK]     = block_complete_i;
      events[dci_pkg::BIT_CELL]      = cell_complete_i;
      events[dci_pkg::BIT_ABORT]     = transfer_abort_i;
      events[dci_pkg::BIT_ADDR_ERR]  = address_error_i;
   end

   // software may write flags either way; a same-cycle event still sets
   assign flag_load = {8{wr_edge & hit_ctrl & sel_i[0]}};  // RL6

   dci_sticky #(.W(8)) u_flags (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .set_i      (events),
      .load_i     (flag_load),
      .load_val_i (dat_i[dci_pkg::FLAG_LSB +: 8]),
      .q_o        (flags)
   );

   // status is a read-to-clear copy of the same events for the system line
   assign stat_clr = {8{rd_edge & hit_status}};

   // a read clears only the bits it returned; an event seen while the
   // read waited for ack stays pending instead of being lost
   assign stat_keep = status & ~dat_ff[7:0];

   dci_sticky #(.W(8)) u_status (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .set_i      (events),
      .load_i     (stat_clr),
      .load_val_i (stat_keep),
      .q_o        (status)
   );

   assign chan_irq_o = |(flags & enables_ff);  // RL7
   assign irq_o      = |(status & mask_ff);

   // checks
   sequence s_ctrl_write;
      req && we_i && hit_ctrl && sel_i[2] && ack_ff;
   endsequence

   property p_enable_store;
      @(posedge clk_i) disable iff (rst_i)
      s_ctrl_write |=> (enables_ff == $past(dat_i[23:16]));
   endproperty

   a_enable_store: assert property (p_enable_store)  // RL1
      else $error("enable bits not stored from write");

   a_src_done_set: assert property (  // RL2
      @(posedge clk_i) disable iff (rst_i)
      $rose(source_pointer_i == source_size_i) |-> ##1 flags[7])
      else $error("source done flag not set");

   a_src_half_set: assert property (  // RL3
      @(posedge clk_i) disable iff (rst_i)
      $rose(source_pointer_i == (source_size_i >> 1)) |=> flags[6])
      else $error("source half flag not set");

   a_dst_done_set: assert property (  // RL4
      @(posedge clk_i) disable iff (rst_i)
      (dest_pointer_i == dest_size_i) && !$past(dest_pointer_i == dest_size_i) |=> flags[5])
      else $error("destination done flag not set");

   a_reserved_zero: assert property (  // RL5
      @(posedge clk_i) disable iff (rst_i)
      $rose(ack_ff) && !we_i && hit_ctrl |-> dat_o[31:24] == 8'h00 && dat_o[15:8] == 8'h00)
      else $error("reserved bits read non-zero");

   a_reset_clear: assert property (  // RL6
      @(posedge clk_i)
      rst_i |=> enables_ff == 8'h00 && flags == 8'h00 && !chan_irq_o)
      else $error("register not cleared by reset");

   a_chan_request: assert property (  // RL7
      @(posedge clk_i) disable iff (rst_i)
      s_ctrl_write ##0 (dat_i[23:16] == 8'h00) |=> !chan_irq_o)
      else $error("channel request with all enables off");

   a_ack_single: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ack_ff |=> !ack_ff)
      else $error("ack held more than one cycle");

   sequence s_flag_write;
      req && we_i && hit_ctrl && sel_i[0] && ack_ff;
   endsequence

   sequence s_mask_write;
      req && we_i && hit_mask && sel_i[0] && ack_ff;
   endsequence

   sequence s_status_read;
      req && !we_i && hit_status && ack_ff;
   endsequence

   // software value lands, except where an event of the same cycle wins
   property p_flag_write;
      @(posedge clk_i) disable iff (rst_i)
      s_flag_write |=> (flags == ($past(dat_i[7:0]) | $past(events)));
   endproperty

   a_flag_write: assert property (p_flag_write)  // RL6
      else $error("flag bits not loaded from write");

   property p_mask_store;
      @(posedge clk_i) disable iff (rst_i)
      s_mask_write |=> (mask_ff == $past(dat_i[7:0]));
   endproperty

   a_mask_store: assert property (p_mask_store)
      else $error("mask bits not stored from write");

   property p_irq_mask_off;
      @(posedge clk_i) disable iff (rst_i)
      s_mask_write ##0 (dat_i[7:0] == 8'h00) |=> !irq_o;
   endproperty

   a_irq_mask_off: assert property (p_irq_mask_off)
      else $error("system interrupt with all mask bits off");

   // the read returns status and clears exactly what it returned
   property p_status_clear;
      @(posedge clk_i) disable iff (rst_i)
      s_status_read ##0 (events == 8'h00) |=> (status == ($past(status) & ~dat_o[7:0]));
   endproperty

   a_status_clear: assert property (p_status_clear)
      else $error("status read cleared the wrong bits");

   property p_event_flag;
      @(posedge clk_i) disable iff (rst_i)
      (events != 8'h00) |=> ((flags & $past(events)) == $past(events));
   endproperty

   a_event_flag: assert property (p_event_flag)
      else $error("event did not set its flag");

   property p_event_status;
      @(posedge clk_i) disable iff (rst_i)
      (events != 8'h00) |=> ((status & $past(events)) == $past(events));
   endproperty

   a_event_status: assert property (p_event_status)
      else $error("event lost from status");

   // flags are sticky: only an event or a flag write may move them
   property p_flags_hold;
      @(posedge clk_i) disable iff (rst_i)
      !(wr_edge && hit_ctrl && sel_i[0]) && (events == 8'h00) |=> $stable(flags);
   endproperty

   a_flags_hold: assert property (p_flags_hold)  // RL6
      else $error("flags changed with no event or write");

   property p_ack_latency;
      @(posedge clk_i) disable iff (rst_i)
      req && !ack_ff |=> ack_ff;
   endproperty

   a_ack_latency: assert property (p_ack_latency)
      else $error("request not acknowledged after one wait state");

   a_ack_cause: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(ack_ff) |-> $past(req))
      else $error("ack without a request");

   a_unmapped_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(ack_ff) && !we_i && !hit_ctrl && !hit_status && !hit_mask
      |-> dat_o == 32'h0000_0000)
      else $error("unmapped read returned non-zero");

   a_reset_quiet: assert property (  // RL6
      @(posedge clk_i)
      rst_i |=> !ack_ff && dat_o == 32'h0000_0000 && !irq_o && status == 8'h00)
      else $error("bus side not quiet after reset");
endmodule : dci_top

// ===== sim/tb_dma_channel_irq_control.sv
/*
 * self-checking bench for the dma channel interrupt control block.
 * assumes the block answers classic wishbone and takes events as pulses.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module tb_dma_channel_irq_control;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o;
   logic [31:0] rd;
   logic [31:0] s;
   logic        ack_o;
   logic        chan_irq_o;
   logic        irq_o;
   logic [15:0] sp = 16'h0000;
   logic [15:0] ss = 16'h0000;
   logic [15:0] dp = 16'h0000;
   logic [15:0] ds = 16'h0000;
   logic [4:0]  evt = 5'h00;
   // model of flags, enables, status and mask
   logic [7:0]  mf = 8'h00;
   logic [7:0]  me = 8'h00;
   logic [7:0]  ms = 8'h00;
   logic [7:0]  mm = 8'h00;
   int          bad_count = 0;
   int          comparisons = 0;
   int          z;

   dci_top dci_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .source_pointer_i(sp), .source_size_i(ss), .dest_pointer_i(dp),
      .dest_size_i(ds), .dest_half_full_i(evt[4]), .block_complete_i(evt[3]),
      .cell_complete_i(evt[2]), .transfer_abort_i(evt[1]), .address_error_i(evt[0]),
      .chan_irq_o(chan_irq_o), .irq_o(irq_o));

   always #4 clk_i = ~clk_i;

   task automatic finish_test;
      if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   // entered just after a rising edge; leaves cyc low for one cycle afterwards
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= b;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 40);
      rd = dat_o;
      if (n >= 40) bad_count++;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 4'hF, 32'h0000_0000);
      `CHK("rdata", e, rd)
   endtask : rchk

   task automatic ichk;
      `CHK("chan_irq", |(mf & me), chan_irq_o)
      `CHK("irq", |(ms & mm), irq_o)
   endtask : ichk

   task automatic ev(input logic [4:0] e);
      evt <= e;
      @(posedge clk_i);
      evt <= 5'h00;
      @(posedge clk_i);
      mf |= {3'b000, e};
      ms |= {3'b000, e};
   endtask : ev

   initial begin
      #160000;
      bad_count++;
      finish_test();
   end

   initial begin
      s = $urandom(82);
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      ichk();
      rchk(8'h00, 32'h0000_0000);
      rchk(8'h04, 32'h0000_0000);
      rchk(8'h08, 32'h0000_0000);
      // unmapped write must be dropped and read as zero
      wb(1'b1, 8'h0C, 4'hF, 32'hFFFF_FFFF);
      rchk(8'h0C, 32'h0000_0000);
      wb(1'b1, 8'h00, 4'hF, 32'hFFFF_FFFF);
      me = 8'hFF;
      mf = 8'hFF;
      rchk(8'h00, 32'h00FF_00FF);
      ichk();
      wb(1'b1, 8'h00, 4'h1, 32'h0000_0000);
      mf = 8'h00;
      rchk(8'h00, 32'h00FF_0000);
      ichk();
      for (int i = 0; i < 40; i++) begin
         s = $urandom;
         wb(1'b1, 8'h00, 4'hF, s);
         me = s[23:16];
         mf = s[7:0];
         mm = s[31:24];
         wb(1'b1, 8'h08, 4'hF, {24'h000000, mm});
         rchk(8'h08, {24'h000000, mm});
         ichk();
         ev(5'($urandom));
         ichk();
         rchk(8'h00, {8'h00, me, 8'h00, mf});
         if (i % 4 == 0) begin
            rchk(8'h04, {24'h000000, ms});
            ms = 8'h00;
            ichk();
         end
      end
      wb(1'b1, 8'h00, 4'hF, 32'h00FF_0000);
      mf = 8'h00;
      me = 8'hFF;
      rchk(8'h04, {24'h000000, ms});
      ms = 8'h00;
      // destination ends one step before source so all three matches land apart
      z = ($urandom % 200) + 4;
      ss <= 16'(z);
      ds <= 16'(z - 1);
      repeat (2) @(posedge clk_i);
      for (int i = 1; i <= z; i++) begin
         sp <= 16'(i);
         dp <= 16'(i);
         @(posedge clk_i);
         if (i == z / 2) begin
            repeat (3) @(posedge clk_i);
            rchk(8'h00, 32'h00FF_0040);
         end
      end
      repeat (3) @(posedge clk_i);
      rchk(8'h00, 32'h00FF_00E0);
      mf = 8'hE0;
      ms = 8'hE0;
      ichk();
      // source pointer stays at its match; cleared flags must not come back
      wb(1'b1, 8'h00, 4'h1, 32'h0000_0000);
      mf = 8'h00;
      repeat (5) @(posedge clk_i);
      rchk(8'h00, 32'h00FF_0000);
      rchk(8'h04, 32'h0000_00E0);
      ms = 8'h00;
      rchk(8'h04, 32'h0000_0000);
      ichk();
      finish_test();
   end
endmodule : tb_dma_channel_irq_control
